// >>> common/ssl_pkg.sv
/*
 * ssl_pkg: constants shared by the serial shift/latch driver ends.
 * Assumes a single 125 MHz system clock at each end.
 */
package ssl_pkg;
	localparam int WORD_BITS      = 12;            // serial word length
	localparam int MSB            = WORD_BITS - 1; // first bit sent
	localparam logic [11:0] RESET_WORD = 12'h000;  // shift and latch reset value
	localparam int CLK_NS         = 8;             // system clock period
	localparam int LINK_HALF_NS   = 80;            // half period of made link clock
	localparam int LINK_HALF_CYC  = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS; // 10 cycles
	localparam int FIFO_DEPTH     = 4;             // words queued at the host end
	localparam int CNT_W          = 4;             // width of bit and divider counters
	localparam logic [3:0] HALF_CNT_LAST = 4'(LINK_HALF_CYC - 1);
	localparam logic [3:0] BIT_LAST      = 4'(WORD_BITS - 1);
endpackage

// >>> common/ssl_if.sv
/*
 * ssl_if: the four-wire serial link plus cascade output.
 * Assumes the host drives clock, data, load and blank; the driver drives cascade.
 */
`timescale 1ns/1ps
interface ssl_if;
	logic shift_clk;  // link clock, made by the host
	logic ser_data;   // serial data to the driver
	logic load;       // latch load, transparent while high
	logic blank;      // forces driver outputs low
	logic cascade;    // last shift stage, for chaining
	modport host (output shift_clk, output ser_data, output load, output blank, input cascade);
	modport drv  (input shift_clk, input ser_data, input load, input blank, output cascade);
endinterface

// >>> core/ssl_fifo.sv
/*
 * ssl_fifo: small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module ssl_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	// system
	input  wire logic             clk,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];  // word store
	logic [AW-1:0]    wr_ptr;       // next write slot
	logic [AW-1:0]    rd_ptr;       // next read slot
	logic [AW:0]      count;        // words held
	wire              do_wr = in_valid & in_ready;
	wire              do_rd = out_valid & out_ready;

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	// store and pointers; depth is a power of two so pointers wrap freely
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_wr) begin
				mem[wr_ptr] <= in_data;
				wr_ptr      <= wr_ptr + 1'b1;
			end
			if (do_rd)
				rd_ptr <= rd_ptr + 1'b1;
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule

// >>> core/ssl_host.sv
/*
 * ssl_host: controller end; queues 12-bit words and sends each MSB first,
 * then pulses load high and back low. Makes the link clock by a divider.
 * Assumes one 125 MHz clock, synchronous active-high reset.
 */
`timescale 1ns/1ps
module ssl_host (
	// system
	input  wire logic        clk,
	input  wire logic        rst,
	// user word stream
	input  wire logic        word_valid,
	output logic             word_ready,
	input  wire logic [11:0] word_data,
	input  wire logic        blank_req,
	output logic             busy,
	// link
	ssl_if.host              link
);
	typedef enum logic [2:0] {SH_IDLE, SH_LOW, SH_HIGH, SH_LOAD_HI, SH_LOAD_LO} ssl_hstate_t;
	ssl_hstate_t state;          // sequencer state
	logic [3:0]  div;            // half-period divider
	logic [3:0]  bit_idx;        // bit being sent
	logic [11:0] word;           // word in flight
	logic        q_valid;        // fifo has a word
	logic [11:0] q_data;         // fifo head
	wire         tick   = (div == ssl_pkg::HALF_CNT_LAST); // half-period enable
	wire         take   = (state == SH_IDLE) & q_valid;
	logic        sck, sdo, ld, blk;

	ssl_fifo #(.WIDTH(12), .DEPTH(ssl_pkg::FIFO_DEPTH)) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.in_valid (word_valid),
		.in_ready (word_ready),
		.in_data  (word_data),
		.out_valid(q_valid),
		.out_ready(take),
		.out_data (q_data)
	);

	assign link.shift_clk = sck;
	assign link.ser_data  = sdo;
	assign link.load      = ld;
	assign link.blank     = blk;
	assign busy           = (state != SH_IDLE);

	// divider, restarted when a word is taken so each phase lasts one half period
	always_ff @(posedge clk) begin
		if (rst || take)
			div <= '0;
		else
			div <= tick ? 4'h0 : div + 4'h1;
	end

	// sequencer: clock held low, 12 bits MSB first, then a load pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			state   <= SH_IDLE;
			sck     <= 1'b0;
			sdo     <= 1'b0;
			ld      <= 1'b0;
			blk     <= 1'b0;
			bit_idx <= '0;
			word    <= ssl_pkg::RESET_WORD;
		end else begin
			blk <= blank_req;
			case (state)
				SH_IDLE: begin
					sck <= 1'b0;
					if (take) begin
						word    <= q_data;
						sdo     <= q_data[ssl_pkg::MSB]; // data set while clock low
						bit_idx <= '0;
						state   <= SH_LOW;
					end
				end
				SH_LOW: if (tick) begin
					sck   <= 1'b1; // data already stable a half period
					state <= SH_HIGH;
				end
				SH_HIGH: if (tick) begin
					sck <= 1'b0;
					if (bit_idx == ssl_pkg::BIT_LAST) begin
						ld    <= 1'b1; // own load line per driver
						state <= SH_LOAD_HI;
					end else begin
						bit_idx <= bit_idx + 4'h1;
						sdo     <= word[4'(ssl_pkg::MSB - 1) - bit_idx]; // next lower bit
						state   <= SH_LOW;
					end
				end
				SH_LOAD_HI: if (tick) begin
					ld    <= 1'b0; // falling edge captures the word
					state <= SH_LOAD_LO;
				end
				SH_LOAD_LO: if (tick)
					state <= SH_IDLE;
				default: state <= SH_IDLE;
			endcase
		end
	end
endmodule

// >>> core/ssl_driver.sv
/*
 * ssl_driver: driver end; 12-bit shift register on the sampled link clock,
 * transparent output latch, blanking gate and cascade output.
 * Assumes all link inputs are asynchronous to clk; rst stands for power-up reset.
 */
`timescale 1ns/1ps
// How it works
// - rising clock shifts, bit 0 takes data
// - load high makes latch follow register
// - load falling captures, held while low
// - blank high forces outputs low only
// - blank low: outputs show latch bits
// - blank never gates shift or latch
// - reset clears register, latch, outputs, cascade
// - cascade shows last stage, falling edge
// - cascade chains into next driver
// - word bit n drives output n
// - host sends 12 bits MSB first, loads
// - host keeps data stable at rising edge
// - load may stay high while shifting
// - every rising edge shifts; last 12 kept
// - separate load line per driver
module ssl_driver (
	// system
	input  wire logic        clk,
	input  wire logic        rst,
	// link
	ssl_if.drv               link,
	// display side
	output logic [11:0]      driver_outputs
);
	logic [1:0]  sck_sync;   // link clock synchroniser
	logic [1:0]  din_sync;   // data synchroniser
	logic [1:0]  ld_sync;    // load synchroniser
	logic [1:0]  blk_sync;   // blank synchroniser
	logic        sck_prev;   // last synced clock, for edges
	logic        ld_prev;    // last synced load
	logic [11:0] shreg;      // shift register
	logic [11:0] latch_q;    // output latch
	logic        casc;       // cascade register

	wire sck      = sck_sync[1];
	wire sck_rise = sck & ~sck_prev;
	wire sck_fall = ~sck & sck_prev;
	wire ld       = ld_sync[1];
	// data path taken from the same synchroniser stage as the edge detect; host holds data a half period
	wire [11:0] next_shreg = {shreg[10:0], din_sync[1]};
	// latch input: follow shifting register when transparent
	wire        ld_fall    = ~ld & ld_prev;

	// two-flop synchronisers, nothing reads stage 0 but stage 1
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_sync <= 2'h0;
			din_sync <= 2'h0;
			ld_sync  <= 2'h0;
			blk_sync <= 2'h0;
			sck_prev <= 1'b0;
			ld_prev  <= 1'b0;
		end else begin
			sck_sync <= {sck_sync[0], link.shift_clk};
			din_sync <= {din_sync[0], link.ser_data};
			ld_sync  <= {ld_sync[0], link.load};
			blk_sync <= {blk_sync[0], link.blank};
			sck_prev <= sck;
			ld_prev  <= ld;
		end
	end

	// shift on every rising edge, whatever load or blank
	always_ff @(posedge clk) begin
		if (rst)
			shreg <= ssl_pkg::RESET_WORD;
		else if (sck_rise)
			shreg <= next_shreg;
	end

	// transparent while load high; the falling edge keeps last value
	always_ff @(posedge clk) begin
		if (rst)
			latch_q <= ssl_pkg::RESET_WORD;
		else if (ld)
			latch_q <= sck_rise ? next_shreg : shreg;
		else if (ld_fall)
			latch_q <= shreg; // capture on load falling, then hold
	end

	// cascade updates on falling clock, so next device samples stable data
	always_ff @(posedge clk) begin
		if (rst)
			casc <= 1'b0;
		else if (sck_fall)
			casc <= shreg[ssl_pkg::MSB];
	end

	// blank gates outputs only, latch untouched
	always_ff @(posedge clk) begin
		if (rst)
			driver_outputs <= ssl_pkg::RESET_WORD;
		else
			driver_outputs <= blk_sync[1] ? 12'h000 : latch_q;
	end

	assign link.cascade = casc;
endmodule

// >>> tb/ssl_monitor.sv
/*
 * ssl_monitor: assertions on the link between host and driver ends.
 * Assumes one clk domain, sync active-high rst, 10-cycle link phases.
 */
`timescale 1ns/1ps
module ssl_monitor (
	// system
	input wire logic clk,
	input wire logic rst,
	// link
	input wire logic shift_clk,
	input wire logic ser_data,
	input wire logic load,
	input wire logic cascade
);
	logic [11:0] sent;   // data seen at each rising link edge, newest in bit 0
	logic [3:0]  hi_run; // cycles the link clock has stood high, saturating
	logic [3:0]  lo_run; // cycles the link clock has stood low, saturating
	logic [3:0]  ld_run; // cycles load has stood high, saturating
	localparam logic [3:0] PHASE_LEN = ssl_pkg::HALF_CNT_LAST + 4'h1; // link phase in clk cycles

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// history model; the driver samples the same stable data, only later
	always_ff @(posedge clk) begin
		if (rst)
			sent <= 12'h000;
		else if ($rose(shift_clk))
			sent <= {sent[10:0], ser_data};
	end

	// run counters; long phases are counted here, not unrolled in sequences
	always_ff @(posedge clk) begin
		if (rst) begin
			hi_run <= 4'h0;
			lo_run <= 4'h0;
			ld_run <= 4'h0;
		end else begin
			hi_run <= shift_clk ? hi_run + {3'h0, hi_run != 4'hF} : 4'h0;
			lo_run <= shift_clk ? 4'h0 : lo_run + {3'h0, lo_run != 4'hF};
			ld_run <= load ? ld_run + {3'h0, ld_run != 4'hF} : 4'h0;
		end
	end

	// link clock still high, then low
	sequence high_end;
		shift_clk ##1 !shift_clk;
	endsequence
	// load still high, then released
	sequence load_end;
		load ##1 !load;
	endsequence

	clear_on_reset_a: assert property (disable iff (1'b0) rst |=> !cascade && !shift_clk && !load)
		else $error("link not idle after reset");
	clock_high_a: assert property ($rose(shift_clk) |-> ##9 high_end)
		else $error("link clock high phase wrong length");
	high_run_a: assert property ($fell(shift_clk) |-> hi_run == PHASE_LEN)
		else $error("link clock high phase broken");
	clock_low_a: assert property ($rose(shift_clk) |-> lo_run >= PHASE_LEN)
		else $error("link clock low phase too short");
	data_hold_a: assert property (shift_clk && $past(shift_clk) |-> $stable(ser_data))
		else $error("serial data moved while clock high");
	load_clock_a: assert property (load |-> !shift_clk)
		else $error("load raised while link clock high");
	load_width_a: assert property ($rose(load) |-> ##9 load_end)
		else $error("load pulse wrong length");
	load_run_a: assert property ($fell(load) |-> ld_run == PHASE_LEN)
		else $error("load pulse broken");
	cascade_edge_a: assert property ($changed(cascade) |-> !shift_clk)
		else $error("cascade moved while link clock high");
	cascade_data_a: assert property ($rose(shift_clk) |-> cascade == sent[11])
		else $error("cascade not the bit sent twelve edges ago");
endmodule

// >>> tb/tb.sv
/*
 * tb: host and driver ends joined by one link; words go in, outputs checked.
 * Assumes 125 MHz clk and a host that drains its queue on its own.
 */
`timescale 1ns/1ps
module tb;
	logic        clk;         // system clock
	logic        rst;         // sync reset
	logic        word_valid;  // word offered
	logic        word_ready;  // queue not full
	logic [11:0] word_data;   // word to send
	logic        blank_req;   // blanking request
	logic        busy;        // host sequencer active
	logic [11:0] outs;        // driver outputs
	int          miscompares; // mismatches
	int          comparisons; // checks made
	int          n;           // words taken

	ssl_if i_ssl_if ();
	ssl_host i_ssl_host (.clk(clk), .rst(rst), .word_valid(word_valid),
		.word_ready(word_ready), .word_data(word_data), .blank_req(blank_req),
		.busy(busy), .link(i_ssl_if));
	ssl_driver i_ssl_driver (.clk(clk), .rst(rst), .link(i_ssl_if), .driver_outputs(outs));
	ssl_monitor i_ssl_monitor (.clk(clk), .rst(rst), .shift_clk(i_ssl_if.shift_clk),
		.ser_data(i_ssl_if.ser_data), .load(i_ssl_if.load), .cascade(i_ssl_if.cascade));

	// clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task tally_and_finish;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// offer up to lim words back to back, stop at the first refusal
	task fill(input logic [11:0] w, input int lim, output int cnt);
		cnt = 0;
		while (cnt < lim) begin
			@(negedge clk);
			if (!word_ready)
				break;
			word_valid = 1'b1;
			word_data  = w + 12'(cnt);
			cnt++;
		end
		@(negedge clk);
		word_valid = 1'b0;
	endtask

	// bounded wait for a quiet host; twelve idle cycles cover driver latency
	task settle;
		int i;
		int q;
		q = 0;
		for (i = 0; i < 4000 && q < 12; i++) begin
			@(negedge clk);
			q = busy ? 0 : q + 1;
		end
		if (q < 12) begin
			miscompares++;
			tally_and_finish();
		end
	endtask

	// bounded wait for the host to raise load at the end of a word
	task wait_load;
		int i;
		for (i = 0; i < 400 && !i_ssl_if.load; i++)
			@(negedge clk);
		if (!i_ssl_if.load) begin
			miscompares++;
			tally_and_finish();
		end
	endtask

	// main sequence
	initial begin
		rst = 1'b1;
		word_valid = 1'b0;
		word_data = 12'h000;
		blank_req = 1'b0;
		miscompares = 0;
		comparisons = 0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		check("outputs at reset", outs, 12'h000);
		check("cascade at reset", {11'h000, i_ssl_if.cascade}, 12'h000);
		fill(12'hA5C, 1, n);
		// latch follows the register while load stands high
		wait_load();
		repeat (6) @(negedge clk);
		check("transparent latch", outs, 12'hA5C);
		settle();
		check("single word", outs, 12'hA5C);
		check("cascade first bit", {11'h000, i_ssl_if.cascade}, 12'h001);
		// queue refuses once full; sequencer holds one more
		fill(12'h8F0, 8, n);
		check("words taken", 12'(n), 12'(ssl_pkg::FIFO_DEPTH + 1));
		check("held while shifting", outs, 12'hA5C);
		settle();
		check("last word", outs, 12'h8F0 + 12'(n - 1));
		check("ready after drain", {11'h000, word_ready}, 12'h001);
		// blanking gates outputs but not shifting or latching
		@(negedge clk);
		blank_req = 1'b1;
		repeat (8) @(negedge clk);
		check("blanked", outs, 12'h000);
		fill(12'h5A3, 1, n);
		settle();
		check("blanked after load", outs, 12'h000);
		blank_req = 1'b0;
		repeat (8) @(negedge clk);
		check("unblanked", outs, 12'h5A3);
		tally_and_finish();
	end
endmodule
